// ---- vcif_pkg.sv ----
package vcif_pkg;

    // ------------------------------------------------------------
    // System register encodings
    // ------------------------------------------------------------
    localparam logic [3:0] VCIF_COPROC = 4'hf;
    localparam logic [2:0] VCIF_OPC1 = 3'h4;
    localparam logic [3:0] VCIF_CRN = 4'hc;
    localparam logic [3:0] VCIF_CRM = 4'hb;
    localparam logic [2:0] VCIF_OPC2_CTRL = 3'h7;
    localparam logic [2:0] VCIF_OPC2_TYPE = 3'h1;
    localparam logic [5:0] VCIF_TRAP_CODE = 6'h03;

    // ------------------------------------------------------------
    // Exception levels
    // ------------------------------------------------------------
    localparam logic [1:0] VCIF_EL_USER = 2'h0;
    localparam logic [1:0] VCIF_EL_KERNEL = 2'h1;
    localparam logic [1:0] VCIF_EL_HYP = 2'h2;
    localparam logic [1:0] VCIF_EL_MON = 2'h3;

    // ------------------------------------------------------------
    // Control register field positions
    // ------------------------------------------------------------
    localparam int VCIF_C_PMASK_LSB = 24;
    localparam int VCIF_C_BP0_LSB = 21;
    localparam int VCIF_C_BP1_LSB = 18;
    localparam int VCIF_C_EOIM = 9;
    localparam int VCIF_C_CBPR = 4;
    localparam int VCIF_C_FIQ = 3;
    localparam int VCIF_C_ACK = 2;
    localparam int VCIF_C_EN1 = 1;
    localparam int VCIF_C_EN0 = 0;
    localparam logic [31:0] VCIF_CTRL_RST = 32'h0000_0000;

    // ------------------------------------------------------------
    // Type register field positions and values
    // ------------------------------------------------------------
    localparam int VCIF_T_PRI_LSB = 29;
    localparam int VCIF_T_PRE_LSB = 26;
    localparam int VCIF_T_ID_LSB = 23;
    localparam int VCIF_T_SYS_ERROR_IRQ_SUPPORT = 22;
    localparam int VCIF_T_A3V = 21;
    localparam int VCIF_T_NODI = 20;
    localparam int VCIF_T_TDS = 19;
    localparam int VCIF_T_LR_LSB = 0;
    localparam logic [2:0] VCIF_ID_16 = 3'h0;
    localparam logic [2:0] VCIF_ID_24 = 3'h1;
    localparam logic [2:0] VCIF_MIN_BITS_M1 = 3'h4;
    localparam logic [4:0] VCIF_LR_MAX_M1 = 5'h0f;

    // ------------------------------------------------------------
    // Virtual interface view
    // ------------------------------------------------------------
    localparam int VCIF_VC_CBPR = 0;
    localparam int VCIF_VC_EOIM = 1;
    localparam int VCIF_VC_FIQ = 2;
    localparam int VCIF_VC_ACK = 3;
    localparam logic [23:0] VCIF_SPURIOUS_ID = 24'h0003fe;
    localparam logic [2:0] VCIF_BP_SAT = 3'h7;

    typedef enum logic [2:0] {
        VCIF_VV_MASK,
        VCIF_VV_BP0,
        VCIF_VV_BP1,
        VCIF_VV_CTRL,
        VCIF_VV_GRPEN0,
        VCIF_VV_GRPEN1
    } vcif_vview_t;

endpackage

// ---- vcif_acc_chk.sv ----
`timescale 1ns/100ps
`default_nettype none
module vcif_acc_chk
    import vcif_pkg::*;
#(
    parameter bit HYP_IMPL = 1'b1
) (
    // Access context
    input wire logic [1:0] i_el,
    input wire logic i_hyp_enabled,
    input wire logic i_hyp_trap_group12,
    input wire logic i_hyp_sysreg_enable,
    input wire logic i_monitor_sysreg_enable,
    // Verdict
    output logic o_ok,
    output logic o_undef,
    output logic o_trap
);

    logic hyp_on;

    assign hyp_on = HYP_IMPL && i_hyp_enabled;

    always_comb begin
        o_ok = 1'b0;
        o_undef = 1'b0;
        o_trap = 1'b0;
        unique case (i_el)
            VCIF_EL_USER: begin
                o_undef = 1'b1;
            end
            VCIF_EL_KERNEL: begin
                o_trap = hyp_on && i_hyp_trap_group12;
                o_undef = !(hyp_on && i_hyp_trap_group12);
            end
            VCIF_EL_HYP: begin
                o_ok = i_hyp_sysreg_enable && HYP_IMPL;
                o_undef = !(i_hyp_sysreg_enable && HYP_IMPL);
            end
            VCIF_EL_MON: begin
                o_ok = i_monitor_sysreg_enable;
                o_undef = !i_monitor_sysreg_enable;
            end
        endcase
    end

endmodule
`default_nettype wire

// ---- vcif_grp_prio.sv ----
`timescale 1ns/100ps
`default_nettype none
module vcif_grp_prio #(
    parameter int PW = 8
) (
    // Priority and number of subpriority bits
    input wire logic [PW-1:0] i_prio,
    input wire logic [3:0] i_sub_bits,
    // Group priority with subpriority cleared
    output logic [PW-1:0] o_group
);

    logic [PW-1:0] keep;

    assign keep = {PW{1'b1}} << i_sub_bits;
    assign o_group = i_prio & keep;

endmodule
`default_nettype wire

// ---- vcif_ctrl.sv ----
// What this block does
// - Signal pending only above priority mask
// - Group 0 split governs group 0 preemption
// - Group 1 split used when common clear
// - Mode 0: end-of-interrupt drops and deactivates
// - Mode 1: end drops only, deactivate separately
// - Common set: group1 view reads group0 plus one, saturating at 7, view writes ignored
// - Bit 3 picks FIQ, fixed one optionally
// - Ack control 0 hides group 1 id
// - Bits 1 and 0 enable the groups
// - Both views share the same storage
// - Warm reset value is not defined
// - Access gated and trapped by exception level
// - No hypervisor: control reads zero from monitor
// - Type bits 31:29 priority width minus one
// - Type bits 28:26 preemption width minus one
// - Type bits 25:23 identifier width code
// - Bits 22 and 21 report error, affinity
// - Bit 20 set: no direct injection
// - No hypervisor: type reads only bit 20
// - Bit 19 reports deactivate trap support
// - Bits 4:0 list register count minus one
`timescale 1ns/100ps
`default_nettype none
module vcif_ctrl
    import vcif_pkg::*;
#(
    parameter bit HYP_IMPL = 1'b1,
    parameter bit SRE_FIXED = 1'b0,
    parameter logic [2:0] PRI_BITS_M1 = VCIF_MIN_BITS_M1,
    parameter logic [2:0] PRE_BITS_M1 = VCIF_MIN_BITS_M1,
    parameter logic [2:0] ID_CODE = VCIF_ID_16,
    parameter bit SYS_ERROR_IRQ_SUPPORT = 1'b0,
    parameter bit A3V = 1'b0,
    parameter bit DEACT_TRAP_SUPPORT = 1'b0,
    parameter logic [4:0] LR_M1 = VCIF_LR_MAX_M1
) (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_rst,
    // System register access from the core
    input wire logic i_acc_valid,
    input wire logic i_acc_write,
    input wire logic [1:0] i_acc_el,
    input wire logic [3:0] i_acc_coproc,
    input wire logic [2:0] i_acc_opc1,
    input wire logic [3:0] i_acc_crn,
    input wire logic [3:0] i_acc_crm,
    input wire logic [2:0] i_acc_opc2,
    input wire logic [31:0] i_acc_wdata,
    output logic o_acc_done,
    output logic o_acc_undef,
    output logic o_acc_trap,
    output logic [5:0] o_acc_trap_code,
    output logic [31:0] o_acc_rdata,
    // Level enables and traps
    input wire logic i_hyp_enabled,
    input wire logic i_hyp_trap_group12,
    input wire logic i_hyp_sysreg_enable,
    input wire logic i_monitor_sysreg_enable,
    // Virtual interface view of the same fields
    input wire logic i_vv_valid,
    input wire logic i_vv_write,
    input wire vcif_vview_t i_vv_sel,
    input wire logic [7:0] i_vv_wdata,
    output logic [7:0] o_vv_rdata,
    // Highest pending virtual interrupt
    input wire logic i_pend_valid,
    input wire logic i_pend_group,
    input wire logic [7:0] i_pend_priority,
    input wire logic [23:0] i_pend_intid,
    input wire logic [7:0] i_running_priority,
    output logic o_virq,
    output logic o_vfiq,
    output logic [23:0] o_ack_intid,
    // End of interrupt and deactivate writes
    input wire logic i_eoi_wr,
    input wire logic i_dir_wr,
    output logic o_prio_drop,
    output logic o_deactivate
);

    // ------------------------------------------------------------
    // Shared field storage
    // ------------------------------------------------------------
    logic [7:0] pmask_r;
    logic [2:0] bp0_r;
    logic [2:0] bp1_r;
    logic eoim_r;
    logic cbpr_r;
    logic fiq_r;
    logic ack_r;
    logic en1_r;
    logic en0_r;

    logic hit_ctrl;
    logic hit_type;
    logic acc_ok;
    logic acc_undef;
    logic acc_trap;
    logic sys_wr;
    logic vv_wr;
    logic fiq_eff;
    logic ack_eff;
    logic [2:0] bp1_view;
    logic [31:0] ctrl_val;
    logic [31:0] type_val;
    logic [31:0] rd_nxt;
    logic [7:0] vv_nxt;

    vcif_acc_chk #(
        .HYP_IMPL(HYP_IMPL)
    ) u_chk (
        .i_el(i_acc_el),
        .i_hyp_enabled(i_hyp_enabled),
        .i_hyp_trap_group12(i_hyp_trap_group12),
        .i_hyp_sysreg_enable(i_hyp_sysreg_enable),
        .i_monitor_sysreg_enable(i_monitor_sysreg_enable),
        .o_ok(acc_ok),
        .o_undef(acc_undef),
        .o_trap(acc_trap)
    );

    assign hit_ctrl = i_acc_coproc == VCIF_COPROC && i_acc_opc1 == VCIF_OPC1
        && i_acc_crn == VCIF_CRN && i_acc_crm == VCIF_CRM
        && i_acc_opc2 == VCIF_OPC2_CTRL;
    assign hit_type = i_acc_coproc == VCIF_COPROC && i_acc_opc1 == VCIF_OPC1
        && i_acc_crn == VCIF_CRN && i_acc_crm == VCIF_CRM
        && i_acc_opc2 == VCIF_OPC2_TYPE;

    // Writes from the monitor are dropped when there is no hypervisor.
    assign sys_wr = i_acc_valid && i_acc_write && hit_ctrl && acc_ok
        && HYP_IMPL;
    // A system register write in the same cycle wins over the view.
    assign vv_wr = i_vv_valid && i_vv_write && !sys_wr;

    assign fiq_eff = SRE_FIXED ? 1'b1 : fiq_r;
    assign ack_eff = SRE_FIXED ? 1'b0 : ack_r;

    assign bp1_view = cbpr_r ? ((bp0_r == VCIF_BP_SAT) ? VCIF_BP_SAT
        : bp0_r + 3'h1) : bp1_r;

    always_comb begin
        ctrl_val = VCIF_CTRL_RST;
        ctrl_val[VCIF_C_PMASK_LSB +: 8] = pmask_r;
        ctrl_val[VCIF_C_BP0_LSB +: 3] = bp0_r;
        ctrl_val[VCIF_C_BP1_LSB +: 3] = bp1_r;
        ctrl_val[VCIF_C_EOIM] = eoim_r;
        ctrl_val[VCIF_C_CBPR] = cbpr_r;
        ctrl_val[VCIF_C_FIQ] = fiq_eff;
        ctrl_val[VCIF_C_ACK] = ack_eff;
        ctrl_val[VCIF_C_EN1] = en1_r;
        ctrl_val[VCIF_C_EN0] = en0_r;
    end

    always_comb begin
        type_val = 32'h0000_0000;
        type_val[VCIF_T_PRI_LSB +: 3] = PRI_BITS_M1;
        type_val[VCIF_T_PRE_LSB +: 3] = PRE_BITS_M1;
        type_val[VCIF_T_ID_LSB +: 3] = ID_CODE;
        type_val[VCIF_T_SYS_ERROR_IRQ_SUPPORT] = SYS_ERROR_IRQ_SUPPORT;
        type_val[VCIF_T_A3V] = A3V;
        type_val[VCIF_T_NODI] = 1'b1;
        type_val[VCIF_T_TDS] = DEACT_TRAP_SUPPORT;
        type_val[VCIF_T_LR_LSB +: 5] = LR_M1;
        if (!HYP_IMPL) begin
            type_val = 32'h0000_0000;
            type_val[VCIF_T_NODI] = 1'b1;
        end
    end

    // ------------------------------------------------------------
    // Field storage, written from either view
    // ------------------------------------------------------------
    // zero is one legal undefined value
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            pmask_r <= VCIF_CTRL_RST[VCIF_C_PMASK_LSB +: 8];
            bp0_r <= VCIF_CTRL_RST[VCIF_C_BP0_LSB +: 3];
            bp1_r <= VCIF_CTRL_RST[VCIF_C_BP1_LSB +: 3];
            eoim_r <= VCIF_CTRL_RST[VCIF_C_EOIM];
            cbpr_r <= VCIF_CTRL_RST[VCIF_C_CBPR];
            fiq_r <= VCIF_CTRL_RST[VCIF_C_FIQ];
            ack_r <= VCIF_CTRL_RST[VCIF_C_ACK];
            en1_r <= VCIF_CTRL_RST[VCIF_C_EN1];
            en0_r <= VCIF_CTRL_RST[VCIF_C_EN0];
        end else if (sys_wr) begin
            pmask_r <= i_acc_wdata[VCIF_C_PMASK_LSB +: 8];
            bp0_r <= i_acc_wdata[VCIF_C_BP0_LSB +: 3];
            bp1_r <= i_acc_wdata[VCIF_C_BP1_LSB +: 3];
            eoim_r <= i_acc_wdata[VCIF_C_EOIM];
            cbpr_r <= i_acc_wdata[VCIF_C_CBPR];
            fiq_r <= i_acc_wdata[VCIF_C_FIQ];
            ack_r <= i_acc_wdata[VCIF_C_ACK];
            en1_r <= i_acc_wdata[VCIF_C_EN1];
            en0_r <= i_acc_wdata[VCIF_C_EN0];
        end else if (vv_wr) begin
            unique case (i_vv_sel)
                VCIF_VV_MASK: pmask_r <= i_vv_wdata;
                VCIF_VV_BP0: bp0_r <= i_vv_wdata[2:0];
                VCIF_VV_BP1: begin
                    if (!cbpr_r) begin
                        bp1_r <= i_vv_wdata[2:0];
                    end
                end
                VCIF_VV_CTRL: begin
                    cbpr_r <= i_vv_wdata[VCIF_VC_CBPR];
                    eoim_r <= i_vv_wdata[VCIF_VC_EOIM];
                    fiq_r <= i_vv_wdata[VCIF_VC_FIQ];
                    ack_r <= i_vv_wdata[VCIF_VC_ACK];
                end
                VCIF_VV_GRPEN0: en0_r <= i_vv_wdata[0];
                VCIF_VV_GRPEN1: en1_r <= i_vv_wdata[0];
                default: pmask_r <= pmask_r;
            endcase
        end
    end

    // ------------------------------------------------------------
    // System register answer, one cycle after the request
    // ------------------------------------------------------------
    always_comb begin
        rd_nxt = 32'h0000_0000;
        if (acc_ok && !i_acc_write && hit_type) begin
            rd_nxt = type_val;
        end else if (acc_ok && !i_acc_write && hit_ctrl) begin
            rd_nxt = HYP_IMPL ? ctrl_val : 32'h0000_0000;
        end
    end

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            o_acc_done <= 1'b0;
            o_acc_undef <= 1'b0;
            o_acc_trap <= 1'b0;
            o_acc_trap_code <= 6'h00;
            o_acc_rdata <= 32'h0000_0000;
        end else begin
            o_acc_done <= i_acc_valid && (hit_ctrl || hit_type);
            // a write to the type register is undefined
            o_acc_undef <= i_acc_valid && ((hit_ctrl && acc_undef)
                || (hit_type && (acc_undef || (acc_ok && i_acc_write))));
            o_acc_trap <= i_acc_valid && (hit_ctrl || hit_type) && acc_trap;
            o_acc_trap_code <= (i_acc_valid && (hit_ctrl || hit_type)
                && acc_trap) ? VCIF_TRAP_CODE : 6'h00;
            o_acc_rdata <= (i_acc_valid && !acc_trap) ? rd_nxt
                : 32'h0000_0000;
        end
    end

    // ------------------------------------------------------------
    // Virtual view read
    // ------------------------------------------------------------
    always_comb begin
        vv_nxt = 8'h00;
        unique case (i_vv_sel)
            VCIF_VV_MASK: vv_nxt = pmask_r;
            VCIF_VV_BP0: vv_nxt = {5'h00, bp0_r};
            VCIF_VV_BP1: vv_nxt = {5'h00, bp1_view};
            VCIF_VV_CTRL: vv_nxt = {4'h0, ack_eff, fiq_eff, eoim_r, cbpr_r};
            VCIF_VV_GRPEN0: vv_nxt = {7'h00, en0_r};
            VCIF_VV_GRPEN1: vv_nxt = {7'h00, en1_r};
            default: vv_nxt = 8'h00;
        endcase
    end

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            o_vv_rdata <= 8'h00;
        end else if (i_vv_valid && !i_vv_write) begin
            o_vv_rdata <= vv_nxt;
        end
    end

    // ------------------------------------------------------------
    // Signalling and preemption
    // ------------------------------------------------------------
    logic [3:0] sub0;
    logic [3:0] sub1;
    logic [7:0] grp0;
    logic [7:0] grp1;
    logic [7:0] pend_grp;
    logic grp_en;
    logic can_signal;

    assign sub0 = {1'b0, bp0_r} + 4'h1;
    assign sub1 = cbpr_r ? sub0 : {1'b0, bp1_r};

    vcif_grp_prio #(
        .PW(8)
    ) u_grp0 (
        .i_prio(i_pend_priority),
        .i_sub_bits(sub0),
        .o_group(grp0)
    );

    vcif_grp_prio #(
        .PW(8)
    ) u_grp1 (
        .i_prio(i_pend_priority),
        .i_sub_bits(sub1),
        .o_group(grp1)
    );

    assign pend_grp = i_pend_group ? grp1 : grp0;
    assign grp_en = i_pend_group ? en1_r : en0_r;
    // mask comparison, lower value is higher priority
    assign can_signal = i_pend_valid && grp_en
        && (i_pend_priority < pmask_r)
        && (pend_grp < i_running_priority);

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            o_virq <= 1'b0;
            o_vfiq <= 1'b0;
        end else begin
            o_vfiq <= can_signal && !i_pend_group && fiq_eff;
            o_virq <= can_signal && (i_pend_group || !fiq_eff);
        end
    end

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            o_ack_intid <= VCIF_SPURIOUS_ID;
        end else begin
            o_ack_intid <= (!i_pend_valid || (i_pend_group && !ack_eff))
                ? VCIF_SPURIOUS_ID : i_pend_intid;
        end
    end

    // ------------------------------------------------------------
    // End of interrupt
    // ------------------------------------------------------------
    // Deactivate writes in mode 0 are unpredictable; they do nothing here.
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            o_prio_drop <= 1'b0;
            o_deactivate <= 1'b0;
        end else begin
            o_prio_drop <= i_eoi_wr;
            o_deactivate <= eoim_r ? i_dir_wr : i_eoi_wr;
        end
    end

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_rst);

    sequence s_ctrl_wr;
        i_acc_valid && i_acc_write && hit_ctrl && acc_ok && HYP_IMPL;
    endsequence

    sequence s_mask_rd;
        i_vv_valid && !i_vv_write && i_vv_sel == VCIF_VV_MASK;
    endsequence

    property p_user_undef;
        i_acc_valid && i_acc_el == VCIF_EL_USER && (hit_ctrl || hit_type)
            |=> o_acc_done && o_acc_undef && !o_acc_trap;
    endproperty
    a_user_undef: assert property (p_user_undef)
        else $error("user level access not undefined");

    property p_kernel_trap;
        i_acc_valid && i_acc_el == VCIF_EL_KERNEL && hit_ctrl
            && i_hyp_enabled && i_hyp_trap_group12 && HYP_IMPL
            |=> o_acc_trap && o_acc_trap_code == 6'h03;
    endproperty
    a_kernel_trap: assert property (p_kernel_trap)
        else $error("kernel access did not trap");

    property p_type_read;
        i_acc_valid && !i_acc_write && hit_type && acc_ok
            |=> o_acc_rdata == $past(type_val) && o_acc_rdata[20];
    endproperty
    a_type_read: assert property (p_type_read)
        else $error("type register read wrong");

    property p_alias;
        s_ctrl_wr ##1 s_mask_rd |=> o_vv_rdata == $past(i_acc_wdata[31:24], 2);
    endproperty
    a_alias: assert property (p_alias)
        else $error("mask not shared between views");

    property p_bp1_common;
        i_vv_valid && !i_vv_write && i_vv_sel == VCIF_VV_BP1 && cbpr_r
            |=> o_vv_rdata[2:0] == (($past(bp0_r) == 3'h7) ? 3'h7
                : $past(bp0_r) + 3'h1);
    endproperty
    a_bp1_common: assert property (p_bp1_common)
        else $error("group 1 binary point not derived");

    property p_mask;
        (o_virq || o_vfiq) |-> $past(i_pend_priority) < $past(pmask_r);
    endproperty
    a_mask: assert property (p_mask)
        else $error("signal at or below the mask");

    property p_disabled;
        !en0_r && !en1_r |=> !o_virq && !o_vfiq;
    endproperty
    a_disabled: assert property (p_disabled)
        else $error("signal while groups disabled");

    property p_eoi_mode0;
        i_eoi_wr && !eoim_r |=> o_prio_drop && o_deactivate;
    endproperty
    a_eoi_mode0: assert property (p_eoi_mode0)
        else $error("mode 0 end did not deactivate");

    property p_eoi_mode1;
        i_eoi_wr && eoim_r && !i_dir_wr |=> o_prio_drop && !o_deactivate;
    endproperty
    a_eoi_mode1: assert property (p_eoi_mode1)
        else $error("mode 1 end deactivated");

    property p_ack_hide;
        i_pend_valid && i_pend_group && !ack_eff
            |=> o_ack_intid == 24'h0003fe;
    endproperty
    a_ack_hide: assert property (p_ack_hide)
        else $error("group 1 id not hidden");

endmodule
`default_nettype wire

// ---- vcif_core_model.sv ----
`timescale 1ns/100ps
`default_nettype none
module vcif_core_model
    import vcif_pkg::*;
(
    // Clock
    input wire logic i_clk,
    // System register request
    output logic o_valid,
    output logic o_write,
    output logic [1:0] o_el,
    output logic [3:0] o_coproc,
    output logic [2:0] o_opc1,
    output logic [3:0] o_crn,
    output logic [3:0] o_crm,
    output logic [2:0] o_opc2,
    output logic [31:0] o_wdata
);
    initial begin
        o_valid = 1'b0;
        o_write = 1'b0;
        o_el = VCIF_EL_USER;
        o_coproc = VCIF_COPROC;
        o_opc1 = VCIF_OPC1;
        o_crn = VCIF_CRN;
        o_crm = VCIF_CRM;
        o_opc2 = 3'h0;
        o_wdata = 32'h0;
    end

    // Released qualifiers flip so stale values never look valid.
    task automatic issue(logic wr, logic [1:0] el, logic [2:0] sel,
                         logic [31:0] wd);
        @(negedge i_clk);
        o_valid = 1'b1;
        o_write = wr;
        o_el = el;
        o_opc2 = sel;
        o_wdata = wd;
        @(negedge i_clk);
        o_valid = 1'b0;
        o_write = ~wr;
        o_opc2 = ~sel;
        o_wdata = ~wd;
    endtask
endmodule
`default_nettype wire

// ---- tb_top.sv ----
`timescale 1ns/100ps
`default_nettype none
module tb_top import vcif_pkg::*; ;
    localparam logic [31:0] MSK = 32'hfffc_021f;
    localparam logic [31:0] TV = {VCIF_MIN_BITS_M1, VCIF_MIN_BITS_M1,
        VCIF_ID_16, 4'h2, 14'h0, VCIF_LR_MAX_M1};
    logic i_clk, i_rst, i_acc_valid, i_acc_write, o_acc_done, o_acc_undef;
    logic o_acc_trap, i_hyp_enabled, i_hyp_trap_group12, i_vv_valid;
    logic i_hyp_sysreg_enable, i_monitor_sysreg_enable, i_vv_write;
    logic i_pend_valid, i_pend_group, o_virq, o_vfiq, i_eoi_wr, i_dir_wr;
    logic o_prio_drop, o_deactivate;
    logic [1:0] i_acc_el;
    logic [3:0] i_acc_coproc, i_acc_crn, i_acc_crm;
    logic [2:0] i_acc_opc1, i_acc_opc2;
    logic [31:0] i_acc_wdata, o_acc_rdata, w;
    logic [5:0] o_acc_trap_code;
    vcif_vview_t i_vv_sel;
    logic [7:0] i_vv_wdata, o_vv_rdata, i_pend_priority, i_running_priority;
    logic [23:0] i_pend_intid, o_ack_intid;
    logic [39:0] exp_q[$];
    int n_errors, tests_run;

    vcif_ctrl vcif_ctrl_i (.i_clk, .i_rst, .i_acc_valid, .i_acc_write,
        .i_acc_el, .i_acc_coproc, .i_acc_opc1, .i_acc_crn, .i_acc_crm,
        .i_acc_opc2, .i_acc_wdata, .o_acc_done, .o_acc_undef, .o_acc_trap,
        .o_acc_trap_code, .o_acc_rdata, .i_hyp_enabled, .i_hyp_trap_group12,
        .i_hyp_sysreg_enable, .i_monitor_sysreg_enable, .i_vv_valid,
        .i_vv_write, .i_vv_sel, .i_vv_wdata, .o_vv_rdata, .i_pend_valid,
        .i_pend_group, .i_pend_priority, .i_pend_intid, .i_running_priority,
        .o_virq, .o_vfiq, .o_ack_intid, .i_eoi_wr, .i_dir_wr, .o_prio_drop,
        .o_deactivate);
    vcif_core_model vcif_core_model_i (.i_clk, .o_valid(i_acc_valid),
        .o_write(i_acc_write), .o_el(i_acc_el), .o_coproc(i_acc_coproc),
        .o_opc1(i_acc_opc1), .o_crn(i_acc_crn), .o_crm(i_acc_crm),
        .o_opc2(i_acc_opc2), .o_wdata(i_acc_wdata));

    initial begin
        i_clk = 1'b0;
        forever #5 i_clk = ~i_clk;
    end

    task automatic chk(string nm, logic [39:0] e, logic [39:0] g);
        tests_run++;
        if (g !== e) begin
            n_errors++;
            $display("MISMATCH %s exp %h got %h", nm, e, g);
        end
    endtask

    task automatic wrap_up();
        $display("tests %0d errors %0d", tests_run, n_errors);
        if (n_errors == 0 && tests_run > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    // An answer with no note behind it is as wrong as a bad answer.
    always @(negedge i_clk) begin
        if (o_acc_done === 1'b1) begin
            if (exp_q.size() == 0)
                chk("stray", 40'h0, 40'h1);
            else
                chk("acc", exp_q.pop_front(), {o_acc_undef, o_acc_trap,
                    o_acc_trap_code, o_acc_rdata});
        end
    end

    task automatic acc(logic wr, logic [1:0] el, logic [2:0] sel,
                       logic [31:0] wd, logic [1:0] ut, logic [31:0] rd);
        exp_q.push_back({ut, ut[0] ? VCIF_TRAP_CODE : 6'h00, rd});
        vcif_core_model_i.issue(wr, el, sel, wd);
    endtask

    task automatic wctl(logic [31:0] wd);
        acc(1'b1, VCIF_EL_HYP, VCIF_OPC2_CTRL, wd, 2'b00, 32'h0);
    endtask

    task automatic vv(logic wr, vcif_vview_t s, logic [7:0] wd,
                      logic [7:0] x);
        @(negedge i_clk);
        i_vv_valid = 1'b1;
        i_vv_write = wr;
        i_vv_sel = s;
        i_vv_wdata = wd;
        @(negedge i_clk);
        i_vv_valid = 1'b0;
        i_vv_wdata = ~wd;
        if (!wr)
            chk("view", x, o_vv_rdata);
    endtask

    task automatic lvl(logic [7:0] pr, logic g, logic [25:0] x);
        @(negedge i_clk);
        i_pend_priority = pr;
        i_pend_group = g;
        repeat (2) @(negedge i_clk);
        chk("signal", x, {o_virq, o_vfiq, o_ack_intid});
    endtask

    task automatic eoi(logic e, logic d, logic [1:0] x);
        @(negedge i_clk);
        i_eoi_wr = e;
        i_dir_wr = d;
        @(negedge i_clk);
        i_eoi_wr = 1'b0;
        i_dir_wr = 1'b0;
        chk("eoi", x, {o_prio_drop, o_deactivate});
    endtask

    initial begin
        #50000;
        n_errors++;
        wrap_up();
    end

    initial begin
        void'($urandom(32'he316));
        {i_rst, i_hyp_enabled, i_hyp_sysreg_enable} = 3'h7;
        {i_monitor_sysreg_enable, i_pend_valid} = 2'h3;
        {i_hyp_trap_group12, i_vv_valid, i_vv_write, i_pend_group} = 4'h0;
        {i_eoi_wr, i_dir_wr, i_vv_wdata} = 10'h0;
        i_vv_sel = VCIF_VV_MASK;
        {i_pend_priority, i_running_priority} = 16'hffff;
        i_pend_intid = 24'h000123;
        repeat (6) @(negedge i_clk);
        chk("rst", 24'h0003fe, o_ack_intid);
        i_rst = 1'b0;
        acc(1'b0, VCIF_EL_HYP, VCIF_OPC2_TYPE, 32'h0, 2'b00, TV);
        acc(1'b1, VCIF_EL_HYP, VCIF_OPC2_TYPE, '1, 2'b10, 32'h0);
        acc(1'b0, VCIF_EL_USER, VCIF_OPC2_TYPE, 32'h0, 2'b10, 32'h0);
        i_hyp_trap_group12 = 1'b1;
        acc(1'b0, VCIF_EL_KERNEL, VCIF_OPC2_CTRL, 32'h0, 2'b01, 32'h0);
        i_hyp_enabled = 1'b0;
        acc(1'b0, VCIF_EL_KERNEL, VCIF_OPC2_CTRL, 32'h0, 2'b10, 32'h0);
        {i_hyp_sysreg_enable, i_monitor_sysreg_enable} = 2'h0;
        acc(1'b0, VCIF_EL_HYP, VCIF_OPC2_CTRL, 32'h0, 2'b10, 32'h0);
        acc(1'b0, VCIF_EL_MON, VCIF_OPC2_TYPE, 32'h0, 2'b10, 32'h0);
        {i_hyp_sysreg_enable, i_monitor_sysreg_enable} = 2'h3;
        vcif_core_model_i.issue(1'b0, VCIF_EL_HYP, 3'h2, 32'h0);
        $display("test access done");
        repeat (4) begin
            w = $urandom() & ~32'h10;
            // A view read one cycle behind the write must see the new mask.
            fork
                wctl(w);
                begin
                    @(negedge i_clk);
                    vv(1'b0, VCIF_VV_MASK, 8'h0, w[31:24]);
                end
            join
            acc(1'b0, VCIF_EL_MON, VCIF_OPC2_CTRL, 0, 2'b00, w & MSK);
            vv(1'b0, VCIF_VV_CTRL, 8'h0, {4'h0, w[2], w[3], w[9], w[4]});
            vv(1'b1, VCIF_VV_MASK, 8'h5a, 8'h0);
            acc(1'b0, VCIF_EL_HYP, VCIF_OPC2_CTRL, 0, 2'b00,
                {8'h5a, w[23:0] & MSK[23:0]});
        end
        $display("test storage done");
        wctl(32'h80e4_0013);
        vv(1'b0, VCIF_VV_BP1, 8'h0, 8'h07);
        vv(1'b1, VCIF_VV_BP1, 8'h02, 8'h0);
        acc(1'b0, VCIF_EL_HYP, VCIF_OPC2_CTRL, 0, 2'b00, 32'h80e4_0013);
        $display("test common done");
        i_running_priority = 8'h42;
        wctl(32'h8020_000b);
        lvl(8'h43, 1'b0, {2'b01, 24'h000123});
        lvl(8'h43, 1'b1, {2'b00, 24'h0003fe});
        wctl(32'h8020_001b);
        lvl(8'h43, 1'b1, {2'b10, 24'h0003fe});
        wctl(32'h8020_001f);
        lvl(8'h43, 1'b1, {2'b10, 24'h000123});
        i_running_priority = 8'hff;
        lvl(8'h80, 1'b0, {2'b00, 24'h000123});
        lvl(8'h7f, 1'b0, {2'b01, 24'h000123});
        wctl(32'h8020_000a);
        lvl(8'h7f, 1'b0, {2'b00, 24'h000123});
        wctl(32'h8020_0003);
        lvl(8'h7f, 1'b0, {2'b10, 24'h000123});
        wctl(32'h8020_0001);
        lvl(8'h7f, 1'b1, {2'b00, 24'h0003fe});
        $display("test signal done");
        eoi(1'b1, 1'b0, 2'b11);
        eoi(1'b0, 1'b1, 2'b00);
        wctl(32'h8020_0203);
        eoi(1'b1, 1'b0, 2'b10);
        eoi(1'b0, 1'b1, 2'b01);
        $display("test eoi done");
        repeat (3) @(negedge i_clk);
        wrap_up();
    end
endmodule
`default_nettype wire
